// >>> ssfc_console.sv
// operator console model: presses resume some cycles after a halt
// assumes halted comes from the block's status
`timescale 1ns/100ps
`default_nettype none
module ssfc_console (
  // clock and status
  input wire logic       sys_clk,
  input wire logic       halted,
  input wire logic [3:0] delay,
  // key
  output logic           resume
);
  // ==========
  // wait then press once
  logic [3:0] wait_ff = 4'h0;
  logic       key_ff = 1'b0;
  always @(posedge sys_clk) begin
    wait_ff <= halted ? wait_ff + 4'h1 : 4'h0;
    key_ff <= halted && wait_ff == delay;
  end
  assign resume = key_ff;
endmodule
`default_nettype wire

// >>> ssfc_core.sv
// stop, skip and fault control for a 30-bit one-address machine
// assumes the sequencer presents one decoded step per valid pulse
`timescale 1ns/100ps
`default_nettype none
`include "ssfc_defines.svh"
// Overview of operation
// - six console selectors choose which manual jumps halt
// - halt on manual jump lights lamp with the j value
// - high-speed mode lights lamp but keeps running
// - high-speed mode ignores programmed stop instructions
// - global clear zeroes every register and designator
// - divide by zero or overflow is a fault; j=3 skips on it
// - divide fault never halts
// - j=1 skips unconditionally
// - product spans accumulator and low register
// - factors handled positive; sign fixed after skip test
// - multiply j=2 skips when low bit 29 is one
// - masked compare with four tests, accumulator unchanged
// - low 15 bits usable as immediate operand
// - real time clock wraps once every seven days
// - return jump records the resumption address
module ssfc_core #(
  parameter int unsigned PRESCALE = `SSFC_CLK_HZ * `SSFC_TICK_SEC
) (
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               reset,
  // console
  input  wire logic               clear_key,
  input  wire logic [5:0]         stop_sel,
  input  wire logic               high_speed,
  input  wire logic               resume,
  input  wire logic               rtc_enable,
  // sequencer
  input  wire ssfc_pkg::ssfc_instr_t instr,
  input  wire ssfc_pkg::ssfc_arith_t arith,
  input  wire logic [14:0]        prog_addr,
  // results
  output var ssfc_pkg::ssfc_status_t status,
  output logic [29:0]             result_acc,
  output logic [29:0]             result_q,
  output logic [29:0]             operand_out,
  output logic [29:0]             rtc_count
);
  typedef struct packed {
    ssfc_pkg::ssfc_state_t  fsm;
    ssfc_pkg::ssfc_status_t stat;
    logic [29:0]            acc;
    logic [29:0]            q;
    logic [29:0]            opnd;
  } ssfc_core_st_t;
  ssfc_core_st_t st_ff, nxt_st;
  // combinational arithmetic terms
  logic [29:0] mag_a, mag_b;   // factor magnitudes
  logic [29:0] quot, rem;      // divide results
  logic [29:0] m_op, m_acc;    // masked compare terms
  logic [5:0]  sel_hit;        // console selector matches
  logic [59:0] prod_raw, prod_fix;
  logic        neg, div_bad, q29_pre, jstop, cmp_res;
  logic [29:0] eff_opnd;
  // =====================================================
  // operand selection
  // immediate half word
  assign eff_opnd = (instr.kfld == `SSFC_K_IMM) ? {`SSFC_ZERO15, instr.yfld} : arith.operand;
  // =====================================================
  // multiply and divide datapath
  // positive factors
  assign mag_a = arith.acc[`SSFC_SIGN_BIT] ? (~arith.acc + 30'h0000_0001) : arith.acc;
  assign mag_b = eff_opnd[`SSFC_SIGN_BIT] ? (~eff_opnd + 30'h0000_0001) : eff_opnd;
  assign neg = arith.acc[`SSFC_SIGN_BIT] ^ eff_opnd[`SSFC_SIGN_BIT];
  // a product of two 30-bit magnitudes always fits the 60-bit pair
  // double length product
  assign prod_raw = {30'h0000_0000, mag_a} * {30'h0000_0000, mag_b};
  assign prod_fix = neg ? (~prod_raw + 60'h000_0000_0000_0001) : prod_raw;
  assign q29_pre = prod_raw[`SSFC_SIGN_BIT];
  // a zero divisor forces zero results so the divider never sees it
  assign quot = (mag_b == `SSFC_ZERO30) ? `SSFC_ZERO30 : mag_a / mag_b;
  assign rem = (mag_b == `SSFC_ZERO30) ? `SSFC_ZERO30 : mag_a % mag_b;
  assign div_bad = (mag_b == `SSFC_ZERO30) || quot[`SSFC_SIGN_BIT];
  // =====================================================
  // masked compare
  // four tests on masked parts
  assign m_op = eff_opnd & arith.mask;
  assign m_acc = arith.acc & arith.mask;
  always_comb begin
    case (arith.cmp_sel)
      `SSFC_CMP_EQ: cmp_res = (m_op == m_acc);
      `SSFC_CMP_NE: cmp_res = (m_op != m_acc);
      `SSFC_CMP_GT: cmp_res = (m_op > m_acc);
      `SSFC_CMP_LT: cmp_res = (m_op < m_acc);
      default:      cmp_res = 1'b0;
    endcase
  end
  // =====================================================
  // manual jump stop selection
  // selector per j value
  // selector bit g guards the manual jump whose j value is g + 1
  generate
    for (genvar g = 0; g < $bits(stop_sel); g++) begin : g_sel
      assign sel_hit[g] = stop_sel[g] && (instr.jfld == 3'(g + 1));
    end
  endgenerate
  // j values 0 and 7 have no selector and never stop
  assign jstop = |sel_hit;
  // =====================================================
  // step sequencing
  always_comb begin
    nxt_st = st_ff;
    case (st_ff.fsm)
      ssfc_pkg::ST_RUN: begin
        if (instr.valid) begin
          // a new step drops the skip, fault and compare flags of the previous one; the stop lamp stays lit
          nxt_st.stat.skip = 1'b0;
          nxt_st.stat.div_fault = 1'b0;
          nxt_st.stat.cmp_true = 1'b0;
          nxt_st.opnd = eff_opnd;
          if (instr.jfld == `SSFC_J_UNCOND) begin
            nxt_st.stat.skip = 1'b1;
          end
          case (instr.func)
            `SSFC_OP_MUL: begin
              nxt_st.acc = prod_fix[59:30];
              nxt_st.q = prod_fix[29:0];
              if (instr.jfld == `SSFC_J_Q29 && q29_pre) begin
                nxt_st.stat.skip = 1'b1;
              end
            end
            `SSFC_OP_DIV: begin
              // quotient takes the factor signs, q keeps the remainder
              // fault never halts
              nxt_st.stat.div_fault = div_bad;
              nxt_st.acc = neg ? (~quot + 30'h0000_0001) : quot;
              nxt_st.q = rem;
              if (instr.jfld == `SSFC_J_FAULT && div_bad) begin
                nxt_st.stat.skip = 1'b1;
              end
            end
            `SSFC_OP_CMPM: begin
              nxt_st.acc = arith.acc;
              nxt_st.stat.cmp_true = cmp_res;
              // a true test skips; j=1 has already set the skip
              if (cmp_res) begin
                nxt_st.stat.skip = 1'b1;
              end
            end
            `SSFC_OP_JMPM, `SSFC_OP_RJMPM: begin
              // manual jumps stop only when their selector is on
              if (jstop) begin
                nxt_st.stat.stop_lamp = 1'b1;
                nxt_st.stat.stop_j = instr.jfld;
                if (!high_speed) begin
                  nxt_st.fsm = ssfc_pkg::ST_HALT;
                  nxt_st.stat.halted = 1'b1;
                end
              end
            end
            `SSFC_OP_STOP: begin
              if (!high_speed) begin
                nxt_st.fsm = ssfc_pkg::ST_HALT;
                nxt_st.stat.halted = 1'b1;
              end
            end
            default: begin
              // other functions pass the accumulator through
              nxt_st.acc = arith.acc;
            end
          endcase
          if (instr.func == `SSFC_OP_RJMPA || instr.func == `SSFC_OP_RJMPM) begin
            nxt_st.stat.return_addr = prog_addr + 15'h0001;
          end
          nxt_st.stat.next_addr = prog_addr + (nxt_st.stat.skip ? 15'h0002 : 15'h0001);
        end
      end
      // halted: steps are ignored until the console resumes
      ssfc_pkg::ST_HALT: begin
        if (resume) begin
          nxt_st.fsm = ssfc_pkg::ST_RUN;
          nxt_st.stat.halted = 1'b0;
          nxt_st.stat.stop_lamp = 1'b0;
        end
      end
      // an unused state code falls back to running
      default: begin
        nxt_st.fsm = ssfc_pkg::ST_RUN;
      end
    endcase
  end
  // state register
  // the clear key acts like reset on every register
  always_ff @(posedge sys_clk) begin
    if (reset || clear_key) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  // =====================================================
  // outputs
  // every output comes straight from a flip-flop
  assign status = st_ff.stat;
  assign result_acc = st_ff.acc;
  assign result_q = st_ff.q;
  assign operand_out = st_ff.opnd;
  // real time clock, also cleared by the console key
  ssfc_rtc #(.PRESCALE(PRESCALE)) u_rtc (
    .sys_clk    (sys_clk),
    .reset      (reset || clear_key),
    .rtc_enable (rtc_enable),
    .rtc_count  (rtc_count)
  );
endmodule
`default_nettype wire

// >>> ssfc_core_props.sv
// checker for the stop, skip and fault control block
// assumes it is bound to ssfc_core and sees only its ports
`timescale 1ns/100ps
`default_nettype none
`include "ssfc_defines.svh"
module ssfc_core_props #(
  parameter int unsigned PRESCALE = 4
) (
  // watched ports
  input wire logic                  sys_clk,
  input wire logic                  reset,
  input wire logic                  clear_key,
  input wire logic [5:0]            stop_sel,
  input wire logic                  high_speed,
  input wire ssfc_pkg::ssfc_instr_t instr,
  input wire ssfc_pkg::ssfc_arith_t arith,
  input wire logic [14:0]           prog_addr,
  input wire ssfc_pkg::ssfc_status_t status,
  input wire logic [29:0]           result_acc,
  input wire logic [29:0]           operand_out,
  input wire logic [29:0]           rtc_count
);
  // ==========
  // taken steps
  wire logic step = instr.valid && !status.halted && !clear_key;
  wire logic man = step && (instr.func == `SSFC_OP_JMPM || instr.func == `SSFC_OP_RJMPM)
    && instr.jfld != 3'h0 && instr.jfld != 3'h7 && stop_sel[instr.jfld - 3'h1];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_stop_halt: assert property (man && !high_speed |=> status.halted && status.stop_lamp
    && status.stop_j == $past(instr.jfld)) else $error("manual jump did not halt");
  a_fast_lamp: assert property (man && high_speed |=> status.stop_lamp && !status.halted)
    else $error("fast mode lamp wrong");
  a_stop_ignored: assert property (step && high_speed && instr.func == `SSFC_OP_STOP
    |=> !status.halted) else $error("stop not ignored");
  a_clear_zero: assert property (clear_key |=> status == '0 && result_acc == '0
    && rtc_count == '0) else $error("clear left state");
  a_div_fault: assert property (step && instr.func == `SSFC_OP_DIV && arith.operand == '0
    && instr.kfld != `SSFC_K_IMM
    |=> status.div_fault && !status.halted) else $error("divide fault wrong");
  a_fault_skip: assert property (step && instr.func == `SSFC_OP_DIV && instr.jfld == 3'h3
    |=> status.skip == status.div_fault) else $error("fault skip wrong");
  a_skip_uncond: assert property (step && instr.jfld == 3'h1 && instr.func[5:3] != 3'h6
    |=> status.skip) else $error("j1 did not skip");
  a_cmp_keeps_acc: assert property (step && instr.func == `SSFC_OP_CMPM
    |=> result_acc == $past(arith.acc)) else $error("compare changed acc");
  a_imm_operand: assert property (step && instr.kfld == `SSFC_K_IMM
    |=> operand_out == {15'h0, $past(instr.yfld)}) else $error("immediate wrong");
  a_rtc_range: assert property (rtc_count < `SSFC_WEEK_SEC) else $error("clock past week");
  a_return_addr: assert property (step && instr.func == `SSFC_OP_RJMPA
    |=> status.return_addr == $past(prog_addr) + 15'h1) else $error("return wrong");
  a_next_addr: assert property (step && instr.func[5:3] != 3'h6 && instr.func != `SSFC_OP_STOP
    |=> status.next_addr == $past(prog_addr) + (status.skip ? 15'h2 : 15'h1))
    else $error("next address wrong");
endmodule
bind ssfc_core ssfc_core_props #(.PRESCALE(PRESCALE)) props_u (.sys_clk(sys_clk),
  .reset(reset), .clear_key(clear_key), .stop_sel(stop_sel), .high_speed(high_speed),
  .instr(instr), .arith(arith), .prog_addr(prog_addr), .status(status),
  .result_acc(result_acc), .operand_out(operand_out), .rtc_count(rtc_count));
`default_nettype wire

// >>> ssfc_core_tb.sv
// testbench for the stop, skip and fault control block
// assumes ssfc_core, ssfc_console and the checker are compiled
`timescale 1ns/100ps
`default_nettype none
`include "ssfc_defines.svh"
module ssfc_core_tb;
  typedef struct {
    logic [5:0] func; logic [2:0] j; logic [29:0] acc, opd, msk;
    logic [1:0] cmp; logic [5:0] sel; logic hs; logic [3:0] exp;
  } ssfc_row_t;
  logic sys_clk = 1'b0, reset = 1'b1, clear_key = 1'b0, high_speed = 1'b0, resume;
  logic rtc_en = 1'b1;
  logic [5:0] stop_sel = 6'h0;
  logic [3:0] rdelay = 4'h0;
  logic [14:0] prog_addr = 15'h0100;
  ssfc_pkg::ssfc_instr_t instr = '0;
  ssfc_pkg::ssfc_arith_t arith = '0;
  ssfc_pkg::ssfc_status_t status;
  logic [29:0] result_acc, result_q, operand_out, rtc_count;
  int errors = 0, n_tests = 0, cyc = 0;
  ssfc_row_t rows[$];
  // ==========
  // clock, design and console
  always #20 sys_clk = ~sys_clk;
  ssfc_core #(.PRESCALE(4)) dut_u (.sys_clk(sys_clk), .reset(reset), .clear_key(clear_key),
    .stop_sel(stop_sel), .high_speed(high_speed), .resume(resume), .rtc_enable(rtc_en),
    .instr(instr), .arith(arith), .prog_addr(prog_addr), .status(status),
    .result_acc(result_acc), .result_q(result_q), .operand_out(operand_out),
    .rtc_count(rtc_count));
  ssfc_console con_u (.sys_clk(sys_clk), .halted(status.halted), .delay(rdelay),
    .resume(resume));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one step, operand from memory (k=1)
  task run(input ssfc_row_t r);
    @(posedge sys_clk); #1;
    instr = '{1'b1, r.func, r.j, 3'h1, 15'h0};
    arith = '{r.acc, r.opd, r.msk, r.acc, r.cmp};
    stop_sel = r.sel;
    high_speed = r.hs;
    @(posedge sys_clk); #1;
    instr.valid = 1'b0;
  endtask
  task settle();
    for (int w = 0; w < 20 && status.halted !== 1'b0; w++) begin
      @(posedge sys_clk);
      #1;
    end
  endtask
  task end_of_test();
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      end_of_test();
    end
  end
  // ==========
  // main sequence
  initial begin
    rows = '{'{`SSFC_OP_DIV, 3'h3, '0, '0, '1, 2'h0, 6'h0, 1'b0, 4'h9},
      '{`SSFC_OP_DIV, 3'h0, '0, '0, '1, 2'h0, 6'h0, 1'b0, 4'h1},
      '{`SSFC_OP_DIV, 3'h3, '0, 30'h1, '1, 2'h0, 6'h0, 1'b0, 4'h0},
      '{6'h10, 3'h1, '0, 30'h1, '1, 2'h0, 6'h0, 1'b0, 4'h8},
      '{6'h10, 3'h0, '0, 30'h1, '1, 2'h0, 6'h0, 1'b0, 4'h0},
      '{`SSFC_OP_MUL, 3'h2, 30'h6000, 30'h6000, '1, 2'h0, 6'h0, 1'b0, 4'h8},
      '{`SSFC_OP_MUL, 3'h2, 30'h1000, 30'h1000, '1, 2'h0, 6'h0, 1'b0, 4'h0},
      '{`SSFC_OP_CMPM, 3'h0, 30'h5, 30'h15, 30'hf, `SSFC_CMP_EQ, 6'h0, 1'b0, 4'h8},
      '{`SSFC_OP_CMPM, 3'h0, 30'h5, 30'h15, 30'hf, `SSFC_CMP_NE, 6'h0, 1'b0, 4'h0},
      '{`SSFC_OP_CMPM, 3'h0, 30'h5, 30'h15, 30'hf, `SSFC_CMP_GT, 6'h0, 1'b0, 4'h0},
      '{`SSFC_OP_CMPM, 3'h0, 30'h5, 30'h15, 30'hf, `SSFC_CMP_LT, 6'h0, 1'b0, 4'h0},
      '{`SSFC_OP_STOP, 3'h0, '0, 30'h1, '1, 2'h0, 6'h0, 1'b1, 4'h0},
      '{`SSFC_OP_JMPM, 3'h3, '0, 30'h1, '1, 2'h0, 6'h3b, 1'b0, 4'h0},
      '{`SSFC_OP_JMPM, 3'h3, '0, 30'h1, '1, 2'h0, 6'h04, 1'b1, 4'h2},
      '{`SSFC_OP_JMPM, 3'h3, '0, 30'h1, '1, 2'h0, 6'h04, 1'b0, 4'h6},
      '{`SSFC_OP_RJMPM, 3'h6, '0, 30'h1, '1, 2'h0, 6'h20, 1'b0, 4'h6},
      '{`SSFC_OP_STOP, 3'h0, '0, 30'h1, '1, 2'h0, 6'h0, 1'b0, 4'h4},
      '{`SSFC_OP_CMPM, 3'h0, 30'h5, 30'h17, 30'hf, `SSFC_CMP_GT, 6'h0, 1'b0, 4'h8},
      '{`SSFC_OP_CMPM, 3'h0, 30'h5, 30'h17, 30'hf, `SSFC_CMP_LT, 6'h0, 1'b0, 4'h0},
      '{`SSFC_OP_CMPM, 3'h1, 30'h5, 30'h15, 30'hf, `SSFC_CMP_NE, 6'h0, 1'b0, 4'h8},
      '{`SSFC_OP_DIV, 3'h3, 30'h2000_0000, 30'h1, '1, 2'h0, 6'h0, 1'b0, 4'h9},
      '{`SSFC_OP_MUL, 3'h2, 30'h3fff_a000, 30'h6000, '1, 2'h0, 6'h0, 1'b0, 4'h8},
      '{`SSFC_OP_MUL, 3'h2, 30'h0010_0000, 30'h0010_0000, '1, 2'h0, 6'h0, 1'b0, 4'h0}};
    repeat (6) @(posedge sys_clk);
    #1 reset = 1'b0;
    foreach (rows[i]) begin
      run(rows[i]);
      // rows cover stops, skips, faults and compares
      check({status.skip, status.halted, status.stop_lamp, status.div_fault}, rows[i].exp);
      settle();
      check(status.halted, 1'b0);
      $display("row %0d done", i);
    end
    // product halves, sign handling, compare flag and next address
    run(rows[21]);
    check(result_acc, 30'h3fff_ffff);
    check(result_q, 30'h1c00_0000);
    run(rows[22]);
    check(result_acc, 30'h0000_0400);
    check(result_q, 30'h0000_0000);
    run(rows[5]);
    check(result_acc, 30'h0000_0000);
    check(result_q, 30'h2400_0000);
    run(rows[17]);
    check(status.cmp_true, 1'b1);
    check(result_acc, 30'h0000_0005);
    run(rows[19]);
    check(status.cmp_true, 1'b0);
    check(status.next_addr, 15'h0102);
    run(rows[2]);
    check(status.next_addr, 15'h0101);
    $display("product and address done");
    // step while halted is ignored
    rdelay = 4'h6;
    run(rows[14]);
    run(rows[0]);
    check({status.halted, status.div_fault}, 2'h2);
    settle();
    check(status.div_fault, 1'b0);
    $display("halt hold done");
    // immediate operand and return point
    instr = '{1'b1, `SSFC_OP_RJMPA, 3'h0, `SSFC_K_IMM, 15'h7abc};
    @(posedge sys_clk); #1;
    instr.valid = 1'b0;
    check(operand_out, 30'h0000_7abc);
    check(status.return_addr, 15'h0101);
    $display("immediate done");
    // clear key zeroes everything, then the clock counts again
    clear_key = 1'b1;
    @(posedge sys_clk); #1;
    clear_key = 1'b0;
    check(|{status, result_acc, result_q, operand_out, rtc_count}, 1'b0);
    repeat (40) @(posedge sys_clk);
    #1 check(rtc_count, 30'h0000_000a);
    // a disabled clock holds its count
    rtc_en = 1'b0;
    repeat (12) @(posedge sys_clk);
    #1 check(rtc_count, 30'h0000_000a);
    $display("clear and clock done");
    end_of_test();
  end
endmodule
`default_nettype wire

// >>> ssfc_defines.svh
// constants for the stop, skip and fault control block
// assumes a single 30-bit one-address machine context
`ifndef SSFC_DEFINES_SVH
`define SSFC_DEFINES_SVH
// word layout
`define SSFC_WORD_W      30
`define SSFC_HALF_W      15
`define SSFC_SIGN_BIT    29
`define SSFC_JFLD_W      3
`define SSFC_JFLD_LO     21
`define SSFC_KFLD_LO     18
`define SSFC_KFLD_W      3
// function codes (octal)
`define SSFC_OP_MUL      6'o22
`define SSFC_OP_DIV      6'o23
`define SSFC_OP_CMPM     6'o43
`define SSFC_OP_JMPM     6'o61
`define SSFC_OP_RJMPA    6'o64
`define SSFC_OP_RJMPM    6'o65
`define SSFC_OP_STOP     6'o77
// skip conditions
`define SSFC_J_UNCOND    3'h1
`define SSFC_J_Q29       3'h2
`define SSFC_J_FAULT     3'h3
// operand interpretation selecting the immediate half word
`define SSFC_K_IMM       3'h0
// compare tests
`define SSFC_CMP_EQ      2'h0
`define SSFC_CMP_NE      2'h1
`define SSFC_CMP_GT      2'h2
`define SSFC_CMP_LT      2'h3
// clock: one tick per second, seven days
`define SSFC_TICK_SEC    1
`define SSFC_CLK_HZ      25000000
`define SSFC_WEEK_SEC    604800
`define SSFC_ZERO30      30'h0000_0000
`define SSFC_ZERO15      15'h0000
`endif

// >>> ssfc_pkg.sv
// types for the stop, skip and fault control block
// assumes ssfc_defines.svh is compiled alongside
package ssfc_pkg;
  typedef enum logic [1:0] {ST_RUN, ST_HALT} ssfc_state_t;
  // one instruction step presented by the sequencer
  typedef struct packed {
    logic        valid;
    logic [5:0]  func;
    logic [2:0]  jfld;
    logic [2:0]  kfld;
    logic [14:0] yfld;
  } ssfc_instr_t;
  // arithmetic operands for the step
  typedef struct packed {
    logic [29:0] acc;
    logic [29:0] operand;
    logic [29:0] mask;
    logic [29:0] qreg;
    logic [1:0]  cmp_sel;
  } ssfc_arith_t;
  // stepping results
  typedef struct packed {
    logic        skip;
    logic        halted;
    logic [2:0]  stop_j;
    logic        stop_lamp;
    logic        div_fault;
    logic        cmp_true;
    logic [14:0] next_addr;
    logic [14:0] return_addr;
  } ssfc_status_t;
endpackage

// >>> ssfc_rtc.sv
// seven-day real time clock counter
// assumes sys_clk at the rate the header names
`timescale 1ns/100ps
`default_nettype none
`include "ssfc_defines.svh"
module ssfc_rtc #(
  parameter int unsigned PRESCALE = `SSFC_CLK_HZ * `SSFC_TICK_SEC,
  parameter int unsigned WRAP     = `SSFC_WEEK_SEC
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // control
  input  wire logic        rtc_enable,
  // count
  output logic [29:0]      rtc_count
);
  typedef struct packed {
    logic [24:0] pre;
    logic [29:0] cnt;
  } ssfc_rtc_st_t;
  ssfc_rtc_st_t st_ff, nxt_st;
  // =====================================================
  // counting
  // weekly wrap
  always_comb begin
    nxt_st = st_ff;
    if (rtc_enable) begin
      if (st_ff.pre == 25'(PRESCALE - 1)) begin
        nxt_st.pre = '0;
        nxt_st.cnt = (st_ff.cnt == 30'(WRAP - 1)) ? `SSFC_ZERO30 : st_ff.cnt + 30'h0000_0001;
      end else begin
        nxt_st.pre = st_ff.pre + 25'h000_0001;
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign rtc_count = st_ff.cnt;
endmodule
`default_nettype wire
